// ==== bench/eeprom_link_sva.sv ====
`default_nettype none

module eeprom_link_sva #(
    parameter int WrHi = 3000,
    parameter int WrLo = 4000
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic sclMasterOe,
    input wire logic sdaMasterOe,
    input wire logic sdaDeviceOe,
    input wire logic writeBusy
);
    timeunit 1ns;
    timeprecision 100ps;

    // ****
    // Link checks
    // ****
    int busyCnt_q;

    always_ff @(posedge core_clk) begin
        if (rst || !writeBusy) busyCnt_q <= 0;
        else busyCnt_q <= busyCnt_q + 1;
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence idleBus;
        scl && sda;
    endsequence

    busy_quiet_a: assert property (writeBusy |-> !sdaDeviceOe)
        else $error("busy device on SDA");
    busy_len_a: assert property ($fell(writeBusy) |-> busyCnt_q == WrHi || busyCnt_q == WrLo)
        else $error("write time wrong");
    busy_start_a: assert property ($rose(writeBusy) |-> idleBus)
        else $error("write began without stop");
    busy_hold_a: assert property ($rose(writeBusy) |-> writeBusy [*8])
        else $error("write cut short");
    dev_edge_a: assert property ($changed(sdaDeviceOe) |-> !scl)
        else $error("SDA moved with SCL high");
    ack_stand_a: assert property (sdaDeviceOe && $rose(scl) |-> sdaDeviceOe [*8])
        else $error("ack dropped early");
    start_hold_a: assert property ($rose(sdaMasterOe) && scl |=> scl [*8])
        else $error("start hold short");
    stop_idle_a: assert property ($fell(sdaMasterOe) && scl |=> idleBus [*8])
        else $error("bus not idle after stop");
endmodule // eeprom_link_sva

`default_nettype wire

// ==== bench/serial_eeprom_i2c_slave_tb.sv ====
`default_nettype none

module serial_eeprom_i2c_slave_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import eeprom_i2c_pkg::*;

    logic       core_clk, rst, cmdValid, cmdReady, cmdRead, cmdSelect, rspValid, rspNack;
    logic       wrValid, wrReady, writeBusy, fastMode, lowSupply, selPin;
    logic [1:0] cmdBlock, memBlock, wrBlock;
    logic [7:0] cmdAddr, cmdData, rspData, memAddr, memRdData, wrAddr, wrData;
    logic [7:0] mem [1024];
    int         err_total, tests_run;

    i2c_link_if link ();
    eeprom_i2c_master #(.QuarterCycles(50)) eeprom_i2c_master_inst (
        .core_clk(core_clk), .rst(rst), .link(link.master), .cmdValid(cmdValid), .cmdReady(cmdReady),
        .cmdRead(cmdRead), .cmdSelect(cmdSelect), .cmdBlock(cmdBlock), .cmdAddr(cmdAddr),
        .cmdData(cmdData), .rspValid(rspValid), .rspData(rspData), .rspNack(rspNack));
    eeprom_i2c_device #(.WriteCyclesHi(3000), .WriteCyclesLo(4000)) eeprom_i2c_device_inst (
        .core_clk(core_clk), .rst(rst), .link(link.device), .deviceSelectPin(selPin), .fastMode(fastMode),
        .lowSupply(lowSupply), .memBlock(memBlock), .memAddr(memAddr), .memRdData(memRdData),
        .wrValid(wrValid), .wrReady(wrReady), .wrBlock(wrBlock), .wrAddr(wrAddr), .wrData(wrData),
        .writeBusy(writeBusy));
    eeprom_link_sva #(.WrHi(3000), .WrLo(4000)) eeprom_link_sva_inst (
        .core_clk(core_clk), .rst(rst), .scl(link.scl), .sda(link.sda), .sclMasterOe(link.sclMasterOe),
        .sdaMasterOe(link.sdaMasterOe), .sdaDeviceOe(link.sdaDeviceOe), .writeBusy(writeBusy));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ****
    // Array stand-in, pops the write buffer
    // ****
    assign memRdData = mem[{memBlock, memAddr}];
    always @(posedge core_clk) begin
        if (wrValid && wrReady) mem[{wrBlock, wrAddr}] <= wrData;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic stuck();
        err_total++;
        $display("[ERR] %0t wait timed out", $time);
        tally_and_finish();
    endtask

    task automatic xfer(input logic rd, input logic sel, input logic [1:0] blk, input logic [7:0] adr, dat);
        int n;
        @(negedge core_clk);
        {cmdRead, cmdSelect, cmdBlock, cmdAddr, cmdData} = {rd, sel, blk, adr, dat};
        cmdValid = 1'b1;
        // Request stands until the edge that sees ready
        for (n = 0; n < 100 && cmdReady !== 1'b1; n++) @(negedge core_clk);
        if (n == 100) stuck();
        @(negedge core_clk);
        cmdValid = 1'b0;
        for (n = 0; n < 20000 && rspValid !== 1'b1; n++) @(negedge core_clk);
        if (n == 20000) stuck();
    endtask

    task automatic idle();
        int n;
        for (n = 0; n < 5000 && writeBusy !== 1'b0; n++) @(negedge core_clk);
        if (n == 5000) stuck();
    endtask

    task automatic t_write();
        xfer(1'b0, 1'b1, 2'h2, 8'h35, 8'hA5);
        chk(rspNack, 8'h00);
        chk(writeBusy, 8'h01);
        chk(mem[10'h235], 8'hA5);
        $display("t_write end");
    endtask

    task automatic t_read();
        xfer(1'b1, 1'b1, 2'h2, 8'h35, 8'h00);
        chk(rspNack, 8'h01);
        idle();
        xfer(1'b1, 1'b1, 2'h2, 8'h35, 8'h00);
        chk(rspData, 8'hA5);
        xfer(1'b1, 1'b1, 2'h1, 8'h35, 8'h00);
        chk(rspData, 8'h35);
        $display("t_read end");
    endtask

    task automatic t_nomatch();
        fastMode = 1'b1;
        xfer(1'b0, 1'b0, 2'h3, 8'h44, 8'hEE);
        chk(rspNack, 8'h01);
        chk(writeBusy, 8'h00);
        chk(mem[10'h344], 8'h44);
        selPin = 1'b0;
        xfer(1'b1, 1'b0, 2'h3, 8'h44, 8'h00);
        chk(rspNack, 8'h00);
        chk(rspData, 8'h44);
        selPin = 1'b1;
        fastMode = 1'b0;
        $display("t_nomatch end");
    endtask

    task automatic t_full();
        lowSupply = 1'b1;
        wrReady = 1'b0;
        xfer(1'b0, 1'b1, 2'h0, 8'h0F, 8'h11);
        idle();
        xfer(1'b0, 1'b1, 2'h0, 8'h20, 8'h22);
        idle();
        xfer(1'b0, 1'b1, 2'h0, 8'h30, 8'h33);
        chk(rspNack, 8'h01);
        wrReady = 1'b1;
        repeat (4) @(negedge core_clk);
        chk(mem[10'h00F], 8'h11);
        chk(mem[10'h020], 8'h22);
        chk(mem[10'h030], 8'h30);
        $display("t_full end");
    endtask

    initial begin
        foreach (mem[i]) mem[i] = 8'(i);
        rst = 1'b1;
        {cmdValid, cmdRead, cmdSelect, cmdBlock, cmdAddr, cmdData} = '0;
        {wrReady, fastMode, lowSupply} = '0;
        selPin = 1'b1;
        err_total = 0;
        tests_run = 0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        wrReady = 1'b1;
        t_write();
        t_read();
        t_nomatch();
        t_full();
        tally_and_finish();
    end
endmodule // serial_eeprom_i2c_slave_tb

`default_nettype wire

// ==== src/eeprom_i2c_device.sv ====
`default_nettype none

module eeprom_i2c_device #(
    parameter logic [3:0] DevTypeCode   = eeprom_i2c_pkg::DEV_TYPE_CODE,
    parameter int         WriteCyclesHi = eeprom_i2c_pkg::WRITE_HI_CYC,
    parameter int         WriteCyclesLo = eeprom_i2c_pkg::WRITE_LO_CYC
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    i2c_link_if.device      link,
    input  wire logic       deviceSelectPin,
    input  wire logic       fastMode,
    input  wire logic       lowSupply,
    output logic [1:0]      memBlock,
    output logic [7:0]      memAddr,
    input  wire logic [7:0] memRdData,
    output logic            wrValid,
    input  wire logic       wrReady,
    output logic [1:0]      wrBlock,
    output logic [7:0]      wrAddr,
    output logic [7:0]      wrData,
    output logic            writeBusy
);
    import eeprom_i2c_pkg::*;

    // ****************************************
    // Pin synchronisers and spike filter
    // ****************************************
    logic [1:0]              pinMeta_q;
    logic [1:0]              pinSync_q;
    logic [1:0]              pinFilt;
    logic [1:0]              pinPrev_q;
    logic                    selMeta_q;
    logic                    selSync_q;
    logic [GLITCH_CNT_W-1:0] glitchLimit;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pinMeta_q <= 2'h3;
            pinSync_q <= 2'h3;
            selMeta_q <= 1'b0;
            selSync_q <= 1'b0;
        end else begin
            pinMeta_q <= {link.scl, link.sda};
            pinSync_q <= pinMeta_q;
            selMeta_q <= deviceSelectPin;
            selSync_q <= selMeta_q;
        end
    end

    assign glitchLimit = fastMode ? GLITCH_FAST_CYC : GLITCH_STD_CYC;

    // A change is taken only after it holds for the full limit
    for (genvar i = 0; i < 2; i++) begin : g_filt
        logic [GLITCH_CNT_W-1:0] cnt_q;
        logic                    filt_q;
        always_ff @(posedge core_clk) begin
            if (rst) begin
                cnt_q  <= '0;
                filt_q <= 1'b1;
            end else if (pinSync_q[i] == filt_q) begin
                cnt_q <= '0;
            end else if (cnt_q == glitchLimit - 1'b1) begin
                filt_q <= pinSync_q[i];
                cnt_q  <= '0;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
        assign pinFilt[i] = filt_q;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pinPrev_q <= 2'h3;
        end else begin
            pinPrev_q <= pinFilt;
        end
    end

    logic sclF;
    logic sdaF;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;

    assign sclF      = pinFilt[1];
    assign sdaF      = pinFilt[0];
    assign sclRise   = sclF & ~pinPrev_q[1];
    assign sclFall   = ~sclF & pinPrev_q[1];
    assign startCond = sclF & pinPrev_q[1] & pinPrev_q[0] & ~sdaF;
    assign stopCond  = sclF & pinPrev_q[1] & ~pinPrev_q[0] & sdaF;

    // ****************************************
    // Self-timed write cycle
    // ****************************************
    logic        busy_q;
    logic [31:0] busyCnt_q;
    logic        wrote_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            busy_q    <= 1'b0;
            busyCnt_q <= '0;
        end else if (busy_q) begin
            if (busyCnt_q == '0) begin
                busy_q <= 1'b0;
            end else begin
                busyCnt_q <= busyCnt_q - 32'h1;
            end
        end else if (stopCond && wrote_q) begin
            busy_q    <= 1'b1;
            busyCnt_q <= lowSupply ? 32'(WriteCyclesLo - 1) : 32'(WriteCyclesHi - 1);
        end
    end

    assign writeBusy = busy_q;

    // ****************************************
    // Two-entry write buffer
    // ****************************************
    logic [17:0] slot0_q;
    logic [17:0] slot1_q;
    logic [1:0]  fifoCnt_q;
    logic        fifoPush;
    logic        fifoPop;
    logic        fifoRoom;
    logic [17:0] pushData;

    assign fifoRoom = (fifoCnt_q != 2'h2);
    assign fifoPop  = wrValid & wrReady;
    assign wrValid  = (fifoCnt_q != 2'h0);
    assign {wrBlock, wrAddr, wrData} = slot0_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            slot0_q   <= '0;
            slot1_q   <= '0;
            fifoCnt_q <= 2'h0;
        end else begin
            if (fifoPop) begin
                slot0_q <= slot1_q;
            end
            if (fifoPush) begin
                if (fifoCnt_q == 2'h0 || (fifoCnt_q == 2'h1 && fifoPop)) begin
                    slot0_q <= pushData;
                end else begin
                    slot1_q <= pushData;
                end
            end
            fifoCnt_q <= fifoCnt_q + {1'b0, fifoPush} - {1'b0, fifoPop};
        end
    end

    // ****************************************
    // Bus protocol engine
    // ****************************************
    dev_state_t             state_q;
    logic [3:0]             bitCnt_q;
    logic [7:0]             shift_q;
    logic                   rw_q;
    logic [BLOCK_SEL_W-1:0] block_q;
    logic [WORD_ADDR_W-1:0] addr_q;
    logic                   sdaLow_q;
    logic                   ackSeen_q;
    logic                   byteDone;

    function automatic logic addrMatch(input logic [7:0] b, input logic sel);
        return (b[TYPE_MSB:TYPE_LSB] == DevTypeCode) && (b[SEL_POS] == sel);
    endfunction

    assign byteDone = (bitCnt_q == 4'(BYTE_BITS));
    assign pushData = {block_q, addr_q, shift_q};
    assign fifoPush = sclFall && !startCond && !stopCond && state_q == DEV_WDATA
                      && byteDone && fifoRoom;

    // SDA is driven only on a filtered SCL fall; start and stop release it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q   <= DEV_IDLE;
            bitCnt_q  <= 4'h0;
            shift_q   <= 8'h00;
            rw_q      <= 1'b0;
            block_q   <= '0;
            addr_q    <= '0;
            sdaLow_q  <= 1'b0;
            ackSeen_q <= 1'b0;
            wrote_q   <= 1'b0;
        end else if (startCond) begin
            sdaLow_q <= 1'b0;
            bitCnt_q <= 4'h0;
            state_q  <= busy_q ? DEV_IGNORE : DEV_ADDR;
        end else if (stopCond) begin
            sdaLow_q <= 1'b0;
            wrote_q  <= 1'b0;
            state_q  <= DEV_IDLE;
        end else if (sclRise) begin
            case (state_q)
                DEV_ADDR, DEV_WORD, DEV_WDATA: begin
                    shift_q  <= {shift_q[6:0], sdaF};
                    bitCnt_q <= bitCnt_q + 4'h1;
                end
                DEV_RDATA_ACK: ackSeen_q <= ~sdaF;
                default: ;
            endcase
        end else if (sclFall) begin
            case (state_q)
                DEV_ADDR: if (byteDone) begin
                    bitCnt_q <= 4'h0;
                    if (addrMatch(shift_q, selSync_q)) begin
                        state_q  <= DEV_ADDR_ACK;
                        sdaLow_q <= 1'b1;
                        rw_q     <= shift_q[RW_POS];
                        block_q  <= shift_q[BLOCK_MSB:BLOCK_LSB];
                    end else begin
                        state_q <= DEV_IGNORE;
                    end
                end
                DEV_ADDR_ACK: begin
                    if (rw_q == RW_READ) begin
                        state_q  <= DEV_RDATA;
                        sdaLow_q <= ~memRdData[7];
                        shift_q  <= {memRdData[6:0], 1'b0};
                        bitCnt_q <= 4'h1;
                    end else begin
                        state_q  <= DEV_WORD;
                        sdaLow_q <= 1'b0;
                    end
                end
                DEV_WORD: if (byteDone) begin
                    addr_q   <= shift_q;
                    sdaLow_q <= 1'b1;
                    bitCnt_q <= 4'h0;
                    state_q  <= DEV_WORD_ACK;
                end
                DEV_WORD_ACK: begin
                    sdaLow_q <= 1'b0;
                    state_q  <= DEV_WDATA;
                end
                DEV_WDATA: if (byteDone) begin
                    bitCnt_q <= 4'h0;
                    // Full buffer: refuse the byte rather than lose it
                    if (fifoRoom) begin
                        sdaLow_q <= 1'b1;
                        wrote_q  <= 1'b1;
                        state_q  <= DEV_WDATA_ACK;
                    end else begin
                        state_q <= DEV_IGNORE;
                    end
                end
                DEV_WDATA_ACK: begin
                    sdaLow_q <= 1'b0;
                    state_q  <= DEV_WDATA;
                    // Wraps inside the aligned page
                    addr_q[PAGE_OFS_W-1:0] <= addr_q[PAGE_OFS_W-1:0] + 1'b1;
                end
                DEV_RDATA: begin
                    if (byteDone) begin
                        sdaLow_q <= 1'b0;
                        addr_q   <= addr_q + 1'b1;
                        state_q  <= DEV_RDATA_ACK;
                    end else begin
                        sdaLow_q <= ~shift_q[7];
                        shift_q  <= {shift_q[6:0], 1'b0};
                        bitCnt_q <= bitCnt_q + 4'h1;
                    end
                end
                DEV_RDATA_ACK: begin
                    if (ackSeen_q) begin
                        state_q  <= DEV_RDATA;
                        sdaLow_q <= ~memRdData[7];
                        shift_q  <= {memRdData[6:0], 1'b0};
                        bitCnt_q <= 4'h1;
                    end else begin
                        state_q <= DEV_IGNORE;
                    end
                end
                default: sdaLow_q <= 1'b0;
            endcase
        end
    end

    assign link.sdaDeviceOut = 1'b0;
    assign link.sdaDeviceOe  = sdaLow_q;
    assign memBlock          = block_q;
    assign memAddr           = addr_q;

endmodule // eeprom_i2c_device

`default_nettype wire

// ==== src/eeprom_i2c_master.sv ====
`default_nettype none

module eeprom_i2c_master #(
    parameter int         QuarterCycles = eeprom_i2c_pkg::SCL_QUARTER_CYC,
    parameter logic [3:0] DevTypeCode   = eeprom_i2c_pkg::DEV_TYPE_CODE
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    i2c_link_if.master      link,
    input  wire logic       cmdValid,
    output logic            cmdReady,
    input  wire logic       cmdRead,
    input  wire logic       cmdSelect,
    input  wire logic [1:0] cmdBlock,
    input  wire logic [7:0] cmdAddr,
    input  wire logic [7:0] cmdData,
    output logic            rspValid,
    output logic [7:0]      rspData,
    output logic            rspNack
);
    import eeprom_i2c_pkg::*;

    // ****************************************
    // Quarter-bit divider and SDA sampler
    // ****************************************
    logic [15:0] div_q;
    logic        tick;
    logic        sdaMeta_q;
    logic        sdaSync_q;

    assign tick = (div_q == 16'(QuarterCycles - 1));

    always_ff @(posedge core_clk) begin
        if (rst || tick) begin
            div_q <= 16'h0;
        end else begin
            div_q <= div_q + 16'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sdaMeta_q <= 1'b1;
            sdaSync_q <= 1'b1;
        end else begin
            sdaMeta_q <= link.sda;
            sdaSync_q <= sdaMeta_q;
        end
    end

    // ****************************************
    // Transaction sequencer
    // ****************************************
    mst_state_t  state_q;
    logic [1:0]  phase_q;
    logic [3:0]  bitIdx_q;
    logic [1:0]  byteNum_q;
    logic [7:0]  txByte_q;
    logic [7:0]  rxByte_q;
    logic        read_q;
    logic        sel_q;
    logic [1:0]  blk_q;
    logic [7:0]  addr_q;
    logic [7:0]  data_q;
    logic        sclLow_q;
    logic        sdaLow_q;
    logic        ackBad_q;
    logic        rdByte;
    logic        lastBit;

    // Byte 0 address/write, 1 word, 2 data or address/read, 3 read
    function automatic logic [7:0] byteFor(input logic [1:0] num);
        case (num)
            2'h0:    return {DevTypeCode, sel_q, blk_q, ~RW_READ};
            2'h1:    return addr_q;
            2'h2:    return read_q ? {DevTypeCode, sel_q, blk_q, RW_READ} : data_q;
            default: return 8'hFF;
        endcase
    endfunction

    assign rdByte   = (byteNum_q == 2'h3);
    assign lastBit  = (bitIdx_q == 4'(BYTE_BITS));
    assign cmdReady = (state_q == MST_IDLE);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q   <= MST_IDLE;
            phase_q   <= 2'h0;
            bitIdx_q  <= 4'h0;
            byteNum_q <= 2'h0;
            txByte_q  <= 8'h00;
            rxByte_q  <= 8'h00;
            read_q    <= 1'b0;
            sel_q     <= 1'b0;
            blk_q     <= 2'h0;
            addr_q    <= 8'h00;
            data_q    <= 8'h00;
            sclLow_q  <= 1'b0;
            sdaLow_q  <= 1'b0;
            ackBad_q  <= 1'b0;
            rspValid  <= 1'b0;
            rspData   <= 8'h00;
            rspNack   <= 1'b0;
        end else begin
            rspValid <= 1'b0;
            case (state_q)
                MST_IDLE: if (cmdValid) begin
                    read_q    <= cmdRead;
                    sel_q     <= cmdSelect;
                    blk_q     <= cmdBlock;
                    addr_q    <= cmdAddr;
                    data_q    <= cmdData;
                    byteNum_q <= 2'h0;
                    phase_q   <= 2'h0;
                    rspNack   <= 1'b0;
                    state_q   <= MST_START;
                end
                MST_START: if (tick) begin
                    phase_q <= phase_q + 2'h1;
                    case (phase_q)
                        2'h0: sdaLow_q <= 1'b0;
                        2'h1: sclLow_q <= 1'b0;
                        2'h2: sdaLow_q <= 1'b1;
                        default: begin
                            sclLow_q <= 1'b1;
                            bitIdx_q <= 4'h0;
                            txByte_q <= byteFor(byteNum_q);
                            state_q  <= MST_BIT;
                        end
                    endcase
                end
                MST_BIT: if (tick) begin
                    phase_q <= phase_q + 2'h1;
                    case (phase_q)
                        // Ack slot released when sending; read byte left unacked
                        2'h0: sdaLow_q <= !lastBit && !rdByte && !txByte_q[7];
                        2'h1: sclLow_q <= 1'b0;
                        2'h2: begin
                            if (!lastBit) begin
                                rxByte_q <= {rxByte_q[6:0], sdaSync_q};
                            end else begin
                                ackBad_q <= sdaSync_q;
                            end
                        end
                        default: begin
                            sclLow_q <= 1'b1;
                            if (!lastBit) begin
                                txByte_q <= {txByte_q[6:0], 1'b0};
                                bitIdx_q <= bitIdx_q + 4'h1;
                            end else if (!rdByte && ackBad_q) begin
                                rspNack <= 1'b1;
                                state_q <= MST_STOP;
                            end else if (rdByte || (byteNum_q == 2'h2 && !read_q)) begin
                                state_q <= MST_STOP;
                            end else if (byteNum_q == 2'h1 && read_q) begin
                                byteNum_q <= 2'h2;
                                state_q   <= MST_START;
                            end else begin
                                byteNum_q <= byteNum_q + 2'h1;
                                bitIdx_q  <= 4'h0;
                                txByte_q  <= byteFor(byteNum_q + 2'h1);
                            end
                        end
                    endcase
                end
                MST_STOP: if (tick) begin
                    phase_q <= phase_q + 2'h1;
                    case (phase_q)
                        2'h0: sdaLow_q <= 1'b1;
                        2'h1: sclLow_q <= 1'b0;
                        2'h2: sdaLow_q <= 1'b0;
                        default: state_q <= MST_DONE;
                    endcase
                end
                MST_DONE: begin
                    rspValid <= 1'b1;
                    rspData  <= rxByte_q;
                    state_q  <= MST_IDLE;
                end
                default: state_q <= MST_IDLE;
            endcase
        end
    end

    assign link.sclMasterOut = 1'b0;
    assign link.sclMasterOe  = sclLow_q;
    assign link.sdaMasterOut = 1'b0;
    assign link.sdaMasterOe  = sdaLow_q;

endmodule // eeprom_i2c_master

`default_nettype wire

// ==== src/eeprom_i2c_pkg.sv ====
`default_nettype none

package eeprom_i2c_pkg;

    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int CLK_PERIOD_NS  = 5;
    localparam int CLK_FREQ_KHZ   = 200000;
    localparam int GLITCH_STD_NS  = 100;
    localparam int GLITCH_FAST_NS = 50;
    localparam int GLITCH_CNT_W   = 5;
    localparam logic [GLITCH_CNT_W-1:0] GLITCH_STD_CYC =
        GLITCH_CNT_W'((GLITCH_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [GLITCH_CNT_W-1:0] GLITCH_FAST_CYC =
        GLITCH_CNT_W'((GLITCH_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int WRITE_TIME_HI_MS = 10;
    localparam int WRITE_TIME_LO_MS = 15;
    localparam int WRITE_HI_CYC     = WRITE_TIME_HI_MS * CLK_FREQ_KHZ;
    localparam int WRITE_LO_CYC     = WRITE_TIME_LO_MS * CLK_FREQ_KHZ;
    localparam int SCL_STD_KHZ      = 100;
    localparam int SCL_QUARTER_CYC  = CLK_FREQ_KHZ / (SCL_STD_KHZ * 4);

    // ****************************************
    // Address byte and memory layout
    // ****************************************
    localparam int TYPE_MSB    = 7;
    localparam int TYPE_LSB    = 4;
    localparam int SEL_POS     = 3;
    localparam int BLOCK_MSB   = 2;
    localparam int BLOCK_LSB   = 1;
    localparam int RW_POS      = 0;
    localparam int BYTE_BITS   = 8;
    localparam int BLOCK_SEL_W = 2;
    localparam int WORD_ADDR_W = 8;
    localparam int PAGE_OFS_W  = 4;
    localparam logic RW_READ   = 1'b1;
    // Arbitrary value, chosen only to be neutral
    localparam logic [3:0] DEV_TYPE_CODE = 4'h6;

    typedef enum logic [3:0] {
        DEV_IDLE, DEV_ADDR, DEV_ADDR_ACK, DEV_WORD, DEV_WORD_ACK,
        DEV_WDATA, DEV_WDATA_ACK, DEV_RDATA, DEV_RDATA_ACK, DEV_IGNORE
    } dev_state_t;

    typedef enum logic [2:0] {
        MST_IDLE, MST_START, MST_BIT, MST_STOP, MST_DONE
    } mst_state_t;

endpackage

`default_nettype wire

// ==== src/i2c_link_if.sv ====
`default_nettype none

interface i2c_link_if;
    logic sclMasterOut;
    logic sclMasterOe;
    logic sdaMasterOut;
    logic sdaMasterOe;
    logic sdaDeviceOut;
    logic sdaDeviceOe;
    logic scl;
    logic sda;

    // Open-drain wired AND with pull-ups
    assign scl = sclMasterOe ? sclMasterOut : 1'b1;
    assign sda = (sdaMasterOe ? sdaMasterOut : 1'b1) & (sdaDeviceOe ? sdaDeviceOut : 1'b1);

    modport master (
        output sclMasterOut,
        output sclMasterOe,
        output sdaMasterOut,
        output sdaMasterOe,
        input  scl,
        input  sda
    );

    modport device (
        output sdaDeviceOut,
        output sdaDeviceOe,
        input  scl,
        input  sda
    );
endinterface

`default_nettype wire
